// ==== rtl/decm_pkg.sv ====
`default_nettype none
// ==========================================
// Shared constants for the data EEPROM access controller
package decm_pkg;
	// Register selects on the core register port
	localparam logic [1:0] SEL_CONTROL = 2'h0;
	localparam logic [1:0] SEL_KEY = 2'h1;
	localparam logic [1:0] SEL_DATA = 2'h2;
	localparam logic [1:0] SEL_ADDRESS = 2'h3;
	// Control register field positions
	localparam int BIT_PROG_SEL = 7;
	localparam int BIT_CFG_SEL = 6;
	localparam int BIT_ROW_ERASE = 4;
	localparam int BIT_ABORT = 3;
	localparam int BIT_WEN = 2;
	localparam int BIT_WSTART = 1;
	localparam int BIT_RSTART = 0;
	// Unlock keys
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// Array size
	localparam int ARRAY_BYTES = 128;
	// Timing: clock and power-up hold-off
	localparam int CLOCK_MHZ = 200;
	localparam int POWERUP_MS = 72;
	localparam int POWERUP_CYCLES = POWERUP_MS * 1000 * CLOCK_MHZ;
	// Default self-timed write length in cycles
	localparam int WRITE_CYCLES = 400;
	// Unlock sequence states
	typedef enum logic [2:0] {
		DECM_KEY_IDLE = 3'b001,
		DECM_KEY_ONE = 3'b010,
		DECM_KEY_TWO = 3'b100
	} decm_key_t;
endpackage
`default_nettype wire

// ==== rtl/decm_array.sv ====
`default_nettype none
// ==========================================
// Byte array with registered read data
module decm_array #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	// Clock
	input wire logic clock,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	// Read port
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [7:0] rd_data
);
	// Storage
	logic [7:0] mem [DEPTH];

	initial begin
		if (DEPTH > (1 << AW)) $error("decm_array depth exceeds address");
	end

	// Erase-before-write is folded into one store of the new byte
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule
`default_nettype wire

// ==== rtl/decm_ctrl.sv ====
`default_nettype none
module decm_ctrl
	import decm_pkg::*;
#(
	parameter int WRITE_LEN = decm_pkg::WRITE_CYCLES,
	parameter int POWERUP_LEN = decm_pkg::POWERUP_CYCLES
) (
	// Clock and resets
	input wire logic clock,
	input wire logic arst_n,
	input wire logic power_on,
	input wire logic warm_reset,
	// Core register port
	input wire logic [1:0] reg_sel,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Status
	output logic write_done_flag,
	input wire logic write_done_clear,
	output logic write_busy
);
	// ==========================================
	// Declarations
	// Whole state of the controller
	typedef struct packed {
		logic [7:0] address;
		logic [7:0] data;
		logic prog_sel;
		logic cfg_sel;
		logic row_erase;
		logic abort;
		logic wen;
		logic wstart;
		logic rstart;
		logic done;
		decm_key_t key;
		logic [$clog2(WRITE_LEN+1)-1:0] wtimer;
		logic [$clog2(POWERUP_LEN+1)-1:0] ptimer;
		logic read_pending;
	} decm_state_t;

	decm_state_t cur;
	decm_state_t next_cur;
	logic [7:0] array_rdata;
	logic array_wr;
	logic array_rd;
	logic [7:0] control_view;
	logic wr_control;
	logic start_ok;

	initial begin
		if (WRITE_LEN < 1) $error("decm_ctrl write length must be positive");
		if (POWERUP_LEN < 1) $error("decm_ctrl power-up length must be positive");
	end

	// ==========================================
	// Storage array
	decm_array #(.DEPTH(ARRAY_BYTES), .AW(7)) u_array (
		.clock(clock),
		.wr_en(array_wr),
		.wr_addr(cur.address[6:0]),
		.wr_data(cur.data),
		.rd_en(array_rd),
		.rd_addr(cur.address[6:0]),
		.rd_data(array_rdata)
	);

	// Control register as software sees it, bit 5 reads zero
	always_comb begin
		control_view = 8'h00;
		control_view[BIT_PROG_SEL] = cur.prog_sel;
		control_view[BIT_CFG_SEL] = cur.cfg_sel;
		control_view[BIT_ROW_ERASE] = cur.row_erase;
		control_view[BIT_ABORT] = cur.abort;
		control_view[BIT_WEN] = cur.wen;
		control_view[BIT_WSTART] = cur.wstart;
		control_view[BIT_RSTART] = cur.rstart;
	end

	// Read mux; key port reads zero
	always_comb begin
		unique case (reg_sel)
			SEL_CONTROL: reg_rdata = control_view;
			SEL_KEY: reg_rdata = 8'h00;
			SEL_DATA: reg_rdata = cur.data;
			SEL_ADDRESS: reg_rdata = cur.address;
		endcase
	end

	// Write start is accepted only in a clean state
	assign wr_control = reg_wr && (reg_sel == SEL_CONTROL);
	assign start_ok = wr_control && reg_wdata[BIT_WSTART] && cur.wen
		&& (cur.key == DECM_KEY_TWO) && (cur.ptimer == '0)
		&& !cur.prog_sel && !cur.cfg_sel;

	// Array strobes: store at end of cycle, read on start
	assign array_wr = cur.wstart && (cur.wtimer == 1);
	assign array_rd = wr_control && reg_wdata[BIT_RSTART] && !cur.wstart
		&& !cur.prog_sel && !cur.cfg_sel;
	assign write_busy = cur.wstart;
	assign write_done_flag = cur.done;

	// ==========================================
	// Next state
	always_comb begin
		next_cur = cur;
		next_cur.rstart = 1'b0;
		next_cur.read_pending = 1'b0;
		// Power-up timer counts down
		if (cur.ptimer != '0) begin
			next_cur.ptimer = cur.ptimer - 1'b1;
		end
		// Read data lands next cycle and holds
		if (cur.read_pending) begin
			next_cur.data = array_rdata;
		end
		// Unlock sequencing on any register write while no write cycle runs
		if (reg_wr && !cur.wstart) begin
			if (reg_sel == SEL_KEY && reg_wdata == KEY_FIRST) begin
				next_cur.key = DECM_KEY_ONE;
			end else if (reg_sel == SEL_KEY && reg_wdata == KEY_SECOND
				&& cur.key == DECM_KEY_ONE) begin
				next_cur.key = DECM_KEY_TWO;
			end else begin
				next_cur.key = DECM_KEY_IDLE;
			end
		end
		if (cur.wstart) begin
			// Self-timed cycle; registers locked
			next_cur.wtimer = cur.wtimer - 1'b1;
			if (cur.wtimer == 1) begin
				next_cur.wstart = 1'b0;
				next_cur.done = 1'b1;
				next_cur.abort = 1'b0;
				next_cur.row_erase = 1'b0;
			end
		end else if (reg_wr) begin
			unique case (reg_sel)
				SEL_CONTROL: begin
					next_cur.prog_sel = reg_wdata[BIT_PROG_SEL];
					next_cur.cfg_sel = reg_wdata[BIT_CFG_SEL];
					next_cur.row_erase = reg_wdata[BIT_ROW_ERASE];
					next_cur.abort = reg_wdata[BIT_ABORT];
					next_cur.wen = reg_wdata[BIT_WEN];
					if (start_ok) begin
						next_cur.wstart = 1'b1;
						next_cur.wtimer = WRITE_LEN[$bits(cur.wtimer)-1:0];
						next_cur.abort = 1'b1;
					end
					if (array_rd) begin
						next_cur.rstart = 1'b1;
						next_cur.read_pending = 1'b1;
					end
				end
				SEL_DATA: next_cur.data = reg_wdata;
				SEL_ADDRESS: next_cur.address = reg_wdata;
				default: begin
				end
			endcase
		end
		// Software clear loses to a same-cycle completion
		if (write_done_clear && !(cur.wstart && cur.wtimer == 1)) begin
			next_cur.done = 1'b0;
		end
		// Warm reset: abort flagged if a write runs, trace bits kept
		if (warm_reset) begin
			next_cur.abort = cur.wstart ? 1'b1 : cur.abort;
			next_cur.wstart = 1'b0;
			next_cur.rstart = 1'b0;
			next_cur.wen = cur.wen;
			next_cur.key = DECM_KEY_IDLE;
			next_cur.wtimer = '0;
			next_cur.read_pending = 1'b0;
		end
		// Power-on clears gate and rearms timer
		if (power_on) begin
			next_cur.wen = 1'b0;
			next_cur.wstart = 1'b0;
			next_cur.abort = 1'b0;
			next_cur.key = DECM_KEY_IDLE;
			next_cur.wtimer = '0;
			next_cur.ptimer = POWERUP_LEN[$bits(cur.ptimer)-1:0];
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cur <= '0;
			cur.key <= DECM_KEY_IDLE;
			cur.ptimer <= POWERUP_LEN[$bits(cur.ptimer)-1:0];
		end else begin
			cur <= next_cur;
		end
	end

	// ==========================================
	// Checks
	AST_DONE_AFTER_WRITE: assert property (@(posedge clock) disable iff (!arst_n)
		cur.wstart && cur.wtimer == 1 && !warm_reset && !power_on
		|=> cur.done && !cur.wstart) else $error("done not set at write end");
	AST_START_NEEDS_KEYS: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(cur.wstart) |-> $past(cur.key) == DECM_KEY_TWO)
		else $error("write started without keys");
	AST_START_NEEDS_GATE: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(cur.wstart) |-> $past(cur.wen)) else $error("write started without gate");
	AST_POWERUP_BLOCK: assert property (@(posedge clock) disable iff (!arst_n)
		cur.ptimer != '0 |=> !$rose(cur.wstart)) else $error("write during power-up");
	AST_READ_ONE_CYCLE: assert property (@(posedge clock) disable iff (!arst_n)
		cur.rstart |=> !cur.rstart) else $error("read start held");
	AST_READ_DATA: assert property (@(posedge clock) disable iff (!arst_n)
		cur.read_pending && !power_on |=> cur.data == $past(array_rdata))
		else $error("read data not loaded");
	AST_LOCKED: assert property (@(posedge clock) disable iff (!arst_n)
		cur.wstart && !warm_reset && !power_on |=> $stable(cur.address) && $stable(cur.data))
		else $error("registers changed during write");
	AST_ABORT_TRACE: assert property (@(posedge clock) disable iff (!arst_n)
		cur.wstart && warm_reset && !power_on |=> cur.abort && $stable(cur.prog_sel))
		else $error("abort not recorded");
	AST_KEY_ZERO: assert property (@(posedge clock) disable iff (!arst_n)
		reg_sel == SEL_KEY |-> reg_rdata == 8'h00) else $error("key port read nonzero");
	COV_WRITE: cover property (@(posedge clock) disable iff (!arst_n) $fell(cur.wstart));
	COV_READ: cover property (@(posedge clock) disable iff (!arst_n) cur.rstart);
	COV_ABORT: cover property (@(posedge clock) disable iff (!arst_n) cur.wstart && warm_reset);
endmodule
`default_nettype wire

// ==== bench/decm_core_model.sv ====
`default_nettype none
// ==========================================
// Core model issuing firmware register accesses
module decm_core_model
	import decm_pkg::*;
(
	// Clock
	input wire logic clock,
	// Register port
	output logic [1:0] reg_sel,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus at time zero
	initial begin
		reg_sel = SEL_CONTROL;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end
	// One strobed write; released data shows the inverse
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		reg_sel = s;
		reg_wr = 1'b1;
		reg_wdata = d;
		@(posedge clock);
		#1 reg_wr = 1'b0;
		reg_wdata = ~d;
		@(posedge clock);
		#1;
	endtask
	// Target and value go in before any start
	task automatic load(input logic [7:0] a, input logic [7:0] d);
		wr(SEL_ADDRESS, a);
		wr(SEL_DATA, d);
	endtask
	// Unlock keys then control write, with nothing between
	task automatic unlock_start(input logic [7:0] c);
		wr(SEL_KEY, KEY_FIRST);
		wr(SEL_KEY, KEY_SECOND);
		wr(SEL_CONTROL, c);
	endtask
	// Select a register and take its value
	task automatic rd(input logic [1:0] s, output logic [7:0] d);
		reg_sel = s;
		#1 d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ==== bench/tb_data_eeprom_access_controller.sv ====
`default_nettype none
// ==========================================
// Bench for the data EEPROM access controller
module tb_data_eeprom_access_controller;
	import decm_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0;
	logic arst_n, power_on, warm_reset, write_done_clear;
	logic [1:0] reg_sel;
	logic reg_wr;
	logic [7:0] reg_wdata, reg_rdata, v, m;
	logic write_done_flag, write_busy;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	// Clock at 5 ns period
	always #2.5 clock = ~clock;
	decm_ctrl #(.WRITE_LEN(4), .POWERUP_LEN(16)) dut_u (.clock(clock), .arst_n(arst_n),
		.power_on(power_on), .warm_reset(warm_reset), .reg_sel(reg_sel), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .write_done_flag(write_done_flag),
		.write_done_clear(write_done_clear), .write_busy(write_busy));
	decm_core_model core_u (.clock(clock), .reg_sel(reg_sel), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	// Verdict and end of run
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Byte compare
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Flag compare
	task automatic chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Register read with expected value
	task automatic rchk(input logic [1:0] s, input logic [7:0] exp);
		core_u.rd(s, v);
		chk8(v, exp);
	endtask
	// Bounded wait for the write to finish
	task automatic wait_idle;
		for (int i = 0; i < 20 && write_busy !== 1'b0; i++) @(posedge clock);
		#1;
	endtask
	// Hang guard
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			print_verdict();
		end
	end
	// Main sequence
	initial begin
		arst_n = 1'b0;
		power_on = 1'b0;
		warm_reset = 1'b0;
		write_done_clear = 1'b0;
		repeat (3) @(posedge clock);
		#1 arst_n = 1'b1;
		rchk(SEL_CONTROL, CONTROL_RESET);
		rchk(SEL_KEY, 8'h00);
		core_u.wr(SEL_CONTROL, 8'h04);
		core_u.unlock_start(8'h06);
		chk1(write_busy, 1'b0);
		repeat (16) @(posedge clock);
		#1 core_u.load(8'h85, 8'h3c);
		core_u.unlock_start(8'h06);
		chk1(write_busy, 1'b1);
		core_u.wr(SEL_DATA, 8'h00);
		wait_idle();
		chk1(write_done_flag, 1'b1);
		rchk(SEL_CONTROL, 8'h04);
		rchk(SEL_DATA, 8'h3c);
		write_done_clear = 1'b1;
		@(posedge clock);
		#1 write_done_clear = 1'b0;
		chk1(write_done_flag, 1'b0);
		core_u.load(8'h05, 8'hff);
		core_u.wr(SEL_CONTROL, 8'h05);
		@(posedge clock);
		#1 rchk(SEL_DATA, 8'h3c);
		rchk(SEL_CONTROL, 8'h04);
		core_u.wr(SEL_KEY, KEY_SECOND);
		core_u.wr(SEL_KEY, KEY_FIRST);
		core_u.wr(SEL_CONTROL, 8'h06);
		core_u.wr(SEL_CONTROL, 8'h00);
		core_u.unlock_start(8'h06);
		for (int i = 0; i < 2; i++) begin
			m = (i == 0) ? 8'h80 : 8'h40;
			core_u.wr(SEL_CONTROL, m | 8'h04);
			core_u.unlock_start(m | 8'h06);
			core_u.wr(SEL_CONTROL, m | 8'h05);
			rchk(SEL_CONTROL, m | 8'h04);
		end
		repeat (6) @(posedge clock);
		#1 chk1(write_done_flag, 1'b0);
		core_u.wr(SEL_CONTROL, 8'h04);
		core_u.unlock_start(8'h06);
		warm_reset = 1'b1;
		@(posedge clock);
		#1 warm_reset = 1'b0;
		rchk(SEL_CONTROL, 8'h0c);
		chk1(write_done_flag, 1'b0);
		rchk(SEL_ADDRESS, 8'h05);
		core_u.wr(SEL_ADDRESS, 8'hff);
		rchk(SEL_ADDRESS, 8'hff);
		power_on = 1'b1;
		@(posedge clock);
		#1 power_on = 1'b0;
		core_u.rd(SEL_CONTROL, v);
		chk1(v[BIT_WEN], 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
